// ---- core/dac_ctrl_pkg.sv ----
package dac_ctrl_pkg;

	// **********************************************************
	// Frame layout
	// **********************************************************
	localparam int FRAME_BITS = 24;
	localparam int DATA_BITS = 20;
	localparam int RW_POS = 23;
	localparam int ADDR_HI = 22;
	localparam int ADDR_LO = 20;
	localparam logic RW_WRITE = 1'h0;
	localparam logic RW_READ = 1'h1;

	// **********************************************************
	// Register addresses
	// **********************************************************
	localparam logic [2:0] ADDR_DAC = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h2;
	localparam logic [2:0] ADDR_CLEAR = 3'h3;
	localparam logic [2:0] ADDR_SWCTRL = 3'h4;

	// **********************************************************
	// Field positions
	// **********************************************************
	localparam int SW_LOAD_POS = 0;
	localparam int SW_CLEAR_POS = 1;
	localparam int SW_RESET_POS = 2;
	localparam int CTRL_FEEDBACK_RESISTOR_SELECT_POS = 1;
	localparam int CTRL_CLAMP_POS = 2;
	localparam int CTRL_FLOAT_POS = 3;
	localparam int CTRL_TWOS_POS = 4;
	localparam int CTRL_LIN_LO = 6;
	localparam int CTRL_LIN_HI = 9;

	// **********************************************************
	// Reset values
	// **********************************************************
	localparam logic [19:0] CLEAR_RESET = 20'h00000;
	localparam logic [19:0] DAC_RESET = 20'h00000;
	localparam logic FEEDBACK_RESISTOR_SELECT_RESET = 1'h0;
	localparam logic CLAMP_RESET = 1'h1;
	localparam logic FLOAT_RESET = 1'h1;
	localparam logic TWOS_RESET = 1'h0;
	localparam logic [3:0] LIN_RESET = 4'h0;
	localparam logic [19:0] CODE_MSB = 20'h80000;

	// Linearity compensation codes per reference span
	localparam logic [3:0] LIN_UP_TO_10V = 4'h0;
	localparam logic [3:0] LIN_10_TO_12V = 4'h1;
	localparam logic [3:0] LIN_12_TO_16V = 4'h2;
	localparam logic [3:0] LIN_16_TO_19V = 4'h3;
	localparam logic [3:0] LIN_19_TO_20V = 4'hC;

	typedef enum logic [1:0] {
		OUT_NORMAL = 2'b00,
		OUT_CLAMPED = 2'b01,
		OUT_FLOATING = 2'b10
	} out_state_t;

endpackage : dac_ctrl_pkg

// ---- core/frame_capture.sv ----
`timescale 1ns/1ps

module frame_capture
(
	// Link
	input wire logic serialClk,
	input wire logic frameSelectN,
	input wire logic serialIn,
	output logic serialOut,
	// Reset
	input wire logic rst,
	// Core side
	input wire logic [23:0] readWord,
	output logic [23:0] frameWord,
	output logic frameToggle
);

	logic [4:0] bitCount;
	logic [23:0] shiftIn;
	logic lastBit;
	logic [4:0] outIndex;

	assign lastBit = (bitCount == 5'(dac_ctrl_pkg::FRAME_BITS - 1));
	assign outIndex = 5'(dac_ctrl_pkg::FRAME_BITS - 1) - bitCount;

	// **********************************************************
	// Bit counter
	// **********************************************************
	// Frame select high restarts the count even while the clock stands
	always_ff @(posedge serialClk or posedge frameSelectN)
	begin
		if (frameSelectN)
			bitCount <= 5'h00;
		else if (!lastBit)
			bitCount <= bitCount + 5'h01;
	end

	// **********************************************************
	// Shift in, hand the word over on the last edge
	// **********************************************************
	always_ff @(posedge serialClk or posedge rst)
	begin
		if (rst)
		begin
			shiftIn <= 24'h000000;
			frameWord <= 24'h000000;
			frameToggle <= 1'h0;
			serialOut <= 1'h0;
		end
		else if (!frameSelectN)
		begin
			shiftIn <= {shiftIn[22:0], serialIn};
			// readWord is held still during a frame by the core, which updates it only in the gap after a read frame
			serialOut <= readWord[outIndex];
			if (lastBit)
			begin
				frameWord <= {shiftIn[22:0], serialIn};
				frameToggle <= ~frameToggle;
			end
		end
	end

endmodule : frame_capture

// ---- core/dac_clear_control_logic.sv ----
// Behaviour
// - Hold a 20-bit clear value written by frames to its address.
// - Clear value is zero after any reset.
// - Clear value is interpreted with the selected binary or twos coding.
// - Software strobe register is write-only; a one acts as a pin pulse.
// - Load strobe at bit 0, clear at bit 1, reset at bit 2.
// - Software clear is ignored while the load pin is low.
// - Software load is ignored while the clear pin is low.
// - Software load updates the DAC register and converter output.
// - Software clear copies the clear value into the DAC register.
// - Software reset returns the device to its power-on state.
// - Power-on resets every register to its default.
// - Power-on floats the converter and clamps output to ground.
// - Clamp bit wins; float alone floats; both clear is normal.
// - Linearity compensation field defaults to 0000.
// - Compensation codes 1, 2, 3 and C cover spans 10 to 20 V.
// - Frame top bit zero writes, one reads.
`timescale 1ns/1ps

module dac_clear_control_logic
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEnable,
	// Serial link
	input wire logic serialClk,
	input wire logic frameSelectN,
	input wire logic serialIn,
	output logic serialOut,
	// Pins
	input wire logic loadOutputStrobeN,
	input wire logic clearToCodeN,
	// Converter side
	output logic [19:0] converterCode,
	output logic [19:0] dacValue,
	output logic outputFloatSelect,
	output logic outputGroundClamp,
	output dac_ctrl_pkg::out_state_t outputState,
	output logic [3:0] linearityComp,
	output logic feedbackResistorSelect,
	output logic twosComplement
);

	// **********************************************************
	// Link domain
	// **********************************************************
	logic [23:0] frameWord;
	logic frameToggle;
	logic [23:0] readWord;

	frame_capture frame_capture_i
	(
		.serialClk(serialClk),
		.frameSelectN(frameSelectN),
		.serialIn(serialIn),
		.serialOut(serialOut),
		.rst(rst),
		.readWord(readWord),
		.frameWord(frameWord),
		.frameToggle(frameToggle)
	);

	// **********************************************************
	// Crossings
	// **********************************************************
	logic [2:0] toggleSync;
	logic [1:0] pinRaw;
	logic [1:0] pinLow;
	logic [23:0] frameHeld;

	assign pinRaw = {clearToCodeN, loadOutputStrobeN};

	// Toggle takes two flops to settle and a third to show its edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			toggleSync <= 3'h0;
		else if (clkEnable)
			toggleSync <= {toggleSync[1:0], frameToggle};
	end

	// Pins are asynchronous, so two flops before any use
	// They reset to the idle high level so no false pulse follows reset
	genvar pinIdx;
	generate
		for (pinIdx = 0; pinIdx < 2; pinIdx = pinIdx + 1)
		begin : pinSync
			logic [1:0] stage;
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
					stage <= 2'h3;
				else if (clkEnable)
					stage <= {stage[0], pinRaw[pinIdx]};
			end
			assign pinLow[pinIdx] = ~stage[1];
		end
	endgenerate

	logic frameEvent;
	logic loadPinLow;
	logic clearPinLow;

	assign frameEvent = toggleSync[2] ^ toggleSync[1];
	assign loadPinLow = pinLow[0];
	assign clearPinLow = pinLow[1];

	// Word is stable long before the toggle arrives here
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			frameHeld <= 24'h000000;
		else if (clkEnable && frameEvent)
			frameHeld <= frameWord;
	end

	// **********************************************************
	// Frame decode
	// **********************************************************
	function automatic logic writeTo(input logic [23:0] word,
		input logic [2:0] target);
		writeTo = (word[dac_ctrl_pkg::RW_POS] == dac_ctrl_pkg::RW_WRITE)
			&& (word[dac_ctrl_pkg::ADDR_HI:dac_ctrl_pkg::ADDR_LO] == target);
	endfunction : writeTo

	logic [2:0] frameAddr;
	logic [19:0] frameData;
	logic frameRead;
	logic validEvent;

	// Decode runs one cycle after capture into frameHeld
	logic eventDelayed;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			eventDelayed <= 1'h0;
		else if (clkEnable)
			eventDelayed <= frameEvent;
	end

	assign validEvent = eventDelayed;
	assign frameAddr = frameHeld[dac_ctrl_pkg::ADDR_HI:dac_ctrl_pkg::ADDR_LO];
	assign frameData = frameHeld[dac_ctrl_pkg::DATA_BITS-1:0];
	assign frameRead = validEvent
		&& frameHeld[dac_ctrl_pkg::RW_POS] == dac_ctrl_pkg::RW_READ;

	logic writeDac;
	logic writeCtrl;
	logic writeClear;
	logic writeSw;

	assign writeDac = validEvent && writeTo(frameHeld, dac_ctrl_pkg::ADDR_DAC);
	assign writeCtrl = validEvent
		&& writeTo(frameHeld, dac_ctrl_pkg::ADDR_CTRL);
	assign writeClear = validEvent
		&& writeTo(frameHeld, dac_ctrl_pkg::ADDR_CLEAR);
	assign writeSw = validEvent
		&& writeTo(frameHeld, dac_ctrl_pkg::ADDR_SWCTRL);

	// **********************************************************
	// Software strobes
	// **********************************************************
	// Decoded straight from the frame, never stored, so no zero write needed
	logic swLoad;
	logic swClear;
	logic softReset;

	assign swLoad = writeSw
		&& frameData[dac_ctrl_pkg::SW_LOAD_POS];
	assign swClear = writeSw
		&& frameData[dac_ctrl_pkg::SW_CLEAR_POS];
	assign softReset = writeSw
		&& frameData[dac_ctrl_pkg::SW_RESET_POS];
	// Bits 19 to 3 feed nothing

	logic doLoad;
	logic doClear;

	// A pin held low counts as a continuous pulse
	assign doClear = clearPinLow || (swClear && !loadPinLow);
	assign doLoad = !doClear
		&& (loadPinLow || (swLoad && !clearPinLow));

	// **********************************************************
	// Registers
	// **********************************************************
	logic [19:0] clearValue;
	logic [19:0] inputValue;
	logic [19:0] next_clearValue;
	logic [19:0] next_inputValue;
	logic [19:0] next_dacValue;
	logic next_feedback_resistor_select;
	logic next_clamp;
	logic next_float;
	logic next_twos;
	logic [3:0] next_lin;

	// Software reset takes the power-on values in the same flops
	assign next_clearValue = softReset ? dac_ctrl_pkg::CLEAR_RESET
		: writeClear ? frameData : clearValue;
	assign next_inputValue = softReset ? dac_ctrl_pkg::DAC_RESET
		: writeDac ? frameData : inputValue;
	assign next_dacValue = softReset ? dac_ctrl_pkg::DAC_RESET
		: doClear ? clearValue
		: doLoad ? inputValue : dacValue;
	assign next_feedback_resistor_select = softReset ? dac_ctrl_pkg::FEEDBACK_RESISTOR_SELECT_RESET
		: writeCtrl ? frameData[dac_ctrl_pkg::CTRL_FEEDBACK_RESISTOR_SELECT_POS]
		: feedbackResistorSelect;
	assign next_clamp = softReset ? dac_ctrl_pkg::CLAMP_RESET
		: writeCtrl ? frameData[dac_ctrl_pkg::CTRL_CLAMP_POS]
		: outputGroundClamp;
	assign next_float = softReset ? dac_ctrl_pkg::FLOAT_RESET
		: writeCtrl ? frameData[dac_ctrl_pkg::CTRL_FLOAT_POS]
		: outputFloatSelect;
	assign next_twos = softReset ? dac_ctrl_pkg::TWOS_RESET
		: writeCtrl ? frameData[dac_ctrl_pkg::CTRL_TWOS_POS]
		: twosComplement;
	assign next_lin = softReset ? dac_ctrl_pkg::LIN_RESET
		: writeCtrl
		? frameData[dac_ctrl_pkg::CTRL_LIN_HI:dac_ctrl_pkg::CTRL_LIN_LO]
		: linearityComp;

	// One short block per register keeps each reset value by its flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			clearValue <= dac_ctrl_pkg::CLEAR_RESET;
		else if (clkEnable)
			clearValue <= next_clearValue;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			inputValue <= dac_ctrl_pkg::DAC_RESET;
		else if (clkEnable)
			inputValue <= next_inputValue;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			dacValue <= dac_ctrl_pkg::DAC_RESET;
		else if (clkEnable)
			dacValue <= next_dacValue;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			feedbackResistorSelect <= dac_ctrl_pkg::FEEDBACK_RESISTOR_SELECT_RESET;
		else if (clkEnable)
			feedbackResistorSelect <= next_feedback_resistor_select;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			outputGroundClamp <= dac_ctrl_pkg::CLAMP_RESET;
		else if (clkEnable)
			outputGroundClamp <= next_clamp;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			outputFloatSelect <= dac_ctrl_pkg::FLOAT_RESET;
		else if (clkEnable)
			outputFloatSelect <= next_float;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			twosComplement <= dac_ctrl_pkg::TWOS_RESET;
		else if (clkEnable)
			twosComplement <= next_twos;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			linearityComp <= dac_ctrl_pkg::LIN_RESET;
		else if (clkEnable)
			linearityComp <= next_lin;
	end

	// **********************************************************
	// Output coding and state
	// **********************************************************
	// Twos complement is offset binary with the top bit flipped
	logic [19:0] next_code;
	dac_ctrl_pkg::out_state_t next_state;

	assign next_code = twosComplement
		? (dacValue ^ dac_ctrl_pkg::CODE_MSB) : dacValue;
	assign next_state = outputGroundClamp ? dac_ctrl_pkg::OUT_CLAMPED
		: outputFloatSelect ? dac_ctrl_pkg::OUT_FLOATING
		: dac_ctrl_pkg::OUT_NORMAL;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			converterCode <= dac_ctrl_pkg::DAC_RESET;
			outputState <= dac_ctrl_pkg::OUT_CLAMPED;
		end
		else if (clkEnable)
		begin
			converterCode <= next_code;
			outputState <= next_state;
		end
	end

	// **********************************************************
	// Readback
	// **********************************************************
	logic [19:0] ctrlRead;
	logic [19:0] readData;

	always_comb
	begin
		ctrlRead = 20'h00000;
		ctrlRead[dac_ctrl_pkg::CTRL_FEEDBACK_RESISTOR_SELECT_POS] = feedbackResistorSelect;
		ctrlRead[dac_ctrl_pkg::CTRL_CLAMP_POS] = outputGroundClamp;
		ctrlRead[dac_ctrl_pkg::CTRL_FLOAT_POS] = outputFloatSelect;
		ctrlRead[dac_ctrl_pkg::CTRL_TWOS_POS] = twosComplement;
		ctrlRead[dac_ctrl_pkg::CTRL_LIN_HI:dac_ctrl_pkg::CTRL_LIN_LO] =
			linearityComp;
	end

	// Write-only strobes and unknown addresses read as zero
	assign readData = (frameAddr == dac_ctrl_pkg::ADDR_DAC) ? inputValue
		: (frameAddr == dac_ctrl_pkg::ADDR_CTRL) ? ctrlRead
		: (frameAddr == dac_ctrl_pkg::ADDR_CLEAR) ? clearValue
		: 20'h00000;

	// Limitation: the next frame shifts this word out, so frames need a gap
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			readWord <= 24'h000000;
		else if (clkEnable && frameRead)
			readWord <= {dac_ctrl_pkg::RW_READ, frameAddr, readData};
	end

endmodule : dac_clear_control_logic

// ---- dv/dac_clear_control_logic_monitor.sv ----
`timescale 1ns/1ps

module dac_clear_control_logic_monitor
(
	// Core
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEnable,
	input wire logic frameSelectN,
	input wire logic loadOutputStrobeN,
	input wire logic clearToCodeN,
	// Outputs
	input wire logic [19:0] converterCode,
	input wire logic [19:0] dacValue,
	input wire logic outputFloatSelect,
	input wire logic outputGroundClamp,
	input wire dac_ctrl_pkg::out_state_t outputState,
	input wire logic [3:0] linearityComp,
	input wire logic feedbackResistorSelect,
	input wire logic twosComplement
);
	// ****************************************
	// Quiet counter
	// ****************************************
	// Long enough to outlast any write still in flight
	logic [3:0] quietCnt;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			quietCnt <= 4'h0;
		// Frozen cycles restart it, a held-back write lands after them
		else if (!clkEnable
			|| !(frameSelectN && loadOutputStrobeN && clearToCodeN))
			quietCnt <= 4'h0;
		else if (quietCnt != 4'hF)
			quietCnt <= quietCnt + 4'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence clearHeld;
		(!clearToCodeN && clkEnable) [*4];
	endsequence
	sequence quietHeld;
		quietCnt == 4'hF && clkEnable;
	endsequence

	AST_STATE_CLAMP: assert property (outputGroundClamp && clkEnable
		|=> outputState == dac_ctrl_pkg::OUT_CLAMPED)
		else $error("clamp bit did not give clamped state");
	AST_STATE_FLOAT: assert property (outputFloatSelect
		&& !outputGroundClamp && clkEnable
		|=> outputState == dac_ctrl_pkg::OUT_FLOATING)
		else $error("float bit did not give floating state");
	AST_STATE_NORMAL: assert property (!outputGroundClamp
		&& !outputFloatSelect && clkEnable
		|=> outputState == dac_ctrl_pkg::OUT_NORMAL)
		else $error("clear bits did not give normal state");
	AST_CODE_TWOS: assert property (clkEnable && twosComplement
		|=> converterCode == ($past(dacValue) ^ dac_ctrl_pkg::CODE_MSB))
		else $error("twos coding not applied to code");
	AST_CODE_BIN: assert property (clkEnable && !twosComplement
		|=> converterCode == $past(dacValue))
		else $error("binary code differs from register");
	AST_CLEAR_PIN: assert property (clearHeld |=> $stable(dacValue))
		else $error("register moved while clear pin held");
	AST_QUIET_HOLD: assert property (quietHeld |=> $stable(dacValue))
		else $error("register moved with no strobe");
	AST_RESET_VALUES: assert property ($fell(rst)
		|-> dacValue == 20'h00000
		&& outputGroundClamp && outputFloatSelect && linearityComp == 4'h0
		&& !feedbackResistorSelect && !twosComplement)
		else $error("reset values wrong");
endmodule : dac_clear_control_logic_monitor

bind dac_clear_control_logic dac_clear_control_logic_monitor
	dac_clear_control_logic_monitor_i
(
	.clk(clk), .rst(rst), .clkEnable(clkEnable), .frameSelectN(frameSelectN),
	.loadOutputStrobeN(loadOutputStrobeN), .clearToCodeN(clearToCodeN),
	.converterCode(converterCode), .dacValue(dacValue),
	.outputFloatSelect(outputFloatSelect),
	.outputGroundClamp(outputGroundClamp), .outputState(outputState),
	.linearityComp(linearityComp),
	.feedbackResistorSelect(feedbackResistorSelect),
	.twosComplement(twosComplement)
);

// ---- dv/serial_host.sv ----
`timescale 1ns/1ps

module serial_host
(
	// Link
	output logic serialClk,
	output logic frameSelectN,
	output logic serialIn,
	input wire logic serialOut
);
	initial
	begin
		serialClk = 1'b0;
		frameSelectN = 1'b1;
		serialIn = 1'b0;
	end

	// Clock runs only inside a frame
	task automatic send(input logic [23:0] w, output logic [23:0] rd);
		#7 frameSelectN = 1'b0;
		for (int i = 23; i >= 0; i--)
		begin
			serialIn = w[i];
			#15 serialClk = 1'b1;
			#15 rd[i] = serialOut;
			serialClk = 1'b0;
		end
		#15 frameSelectN = 1'b1;
		// Released line flips so a stale bit cannot pass as data
		serialIn = ~serialIn;
	endtask : send
endmodule : serial_host

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
	logic clk;
	logic rst;
	logic clkEnable;
	logic loadOutputStrobeN;
	logic clearToCodeN;
	logic serialClk, frameSelectN, serialIn, serialOut;
	logic [19:0] converterCode, dacValue;
	logic outputFloatSelect, outputGroundClamp, rbufOut, twosOut;
	logic [3:0] linearityComp;
	dac_ctrl_pkg::out_state_t outputState;
	typedef struct packed {
		logic [19:0] dac;
		logic [1:0] st;
		logic [3:0] lin;
		logic feedback_resistor_select;
		logic twos;
		logic flt;
	} exp_t;
	exp_t expQ[$];
	logic [23:0] rdQ[$];
	event resultReady, readReady;
	logic [23:0] rdWord;
	logic [19:0] cv, dv;
	logic [3:0] lin;
	logic rb;
	logic fl;
	logic [3:0] linCodes [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hC};
	int errCount = 0;
	int totalChecks = 0;
	int seed;

	dac_clear_control_logic dac_clear_control_logic_i
	(
		.clk(clk), .rst(rst), .clkEnable(clkEnable), .serialClk(serialClk),
		.frameSelectN(frameSelectN), .serialIn(serialIn),
		.serialOut(serialOut), .loadOutputStrobeN(loadOutputStrobeN),
		.clearToCodeN(clearToCodeN), .converterCode(converterCode),
		.dacValue(dacValue), .outputFloatSelect(outputFloatSelect),
		.outputGroundClamp(outputGroundClamp), .outputState(outputState),
		.linearityComp(linearityComp), .feedbackResistorSelect(rbufOut),
		.twosComplement(twosOut)
	);
	serial_host serial_host_i
	(
		.serialClk(serialClk), .frameSelectN(frameSelectN),
		.serialIn(serialIn), .serialOut(serialOut)
	);

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] g);
		totalChecks++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			errCount++;
		end
	endtask : chk

	// Wait covers sync, write and output register stages
	task automatic frame(input logic [23:0] w);
		serial_host_i.send(w, rdWord);
		repeat (14) @(posedge clk);
		#5;
	endtask : frame

	task automatic wr(input logic [2:0] a, input logic [19:0] d);
		frame({dac_ctrl_pkg::RW_WRITE, a, d});
	endtask : wr

	function automatic logic [19:0] ctrlWord(input logic t, input logic f,
		input logic c);
		return {10'h000, lin, 1'b0, t, f, c, rb, 1'b0};
	endfunction : ctrlWord

	task automatic expect_out(input logic [19:0] d, input logic [1:0] s,
		input logic t);
		expQ.push_back({d, s, lin, rb, t, fl});
		-> resultReady;
	endtask : expect_out

	task automatic final_report;
		$display("checks %0d errors %0d", totalChecks, errCount);
		if (errCount == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	// ****************************************
	// Watchers
	// ****************************************
	initial
	begin : watchOut
		exp_t e;
		logic [19:0] code;
		forever
		begin
			@(resultReady);
			e = expQ.pop_front();
			code = e.twos ? (e.dac ^ dac_ctrl_pkg::CODE_MSB) : e.dac;
			chk("dacValue", {4'h0, e.dac}, {4'h0, dacValue});
			chk("converterCode", {4'h0, code}, {4'h0, converterCode});
			chk("outputState", {22'h0, e.st}, {22'h0, outputState});
			chk("float", {23'h0, e.flt}, {23'h0, outputFloatSelect});
			chk("clamp", {23'h0, e.st == 2'b01},
				{23'h0, outputGroundClamp});
			chk("linearityComp", {20'h0, e.lin}, {20'h0, linearityComp});
			chk("feedback_resistor_select", {23'h0, e.feedback_resistor_select}, {23'h0, rbufOut});
			chk("twos", {23'h0, e.twos}, {23'h0, twosOut});
		end
	end
	initial
	begin
		forever
		begin
			@(readReady);
			chk("readback", rdQ.pop_front(), rdWord);
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#500000;
		errCount++;
		final_report;
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		clkEnable = 1'b1;
		loadOutputStrobeN = 1'b1;
		clearToCodeN = 1'b1;
		lin = 4'h0;
		rb = 1'b0;
		fl = 1'b1;
		seed = $urandom(32'h20026d25);
		repeat (5) @(posedge clk);
		#5 rst = 1'b0;
		repeat (2) @(posedge clk);
		#5;
		expect_out(20'h0, dac_ctrl_pkg::OUT_CLAMPED, 1'b0);
		for (int i = 0; i < 5; i++)
		begin
			lin = linCodes[i];
			fl = i[0];
			rb = 1'($urandom);
			wr(dac_ctrl_pkg::ADDR_CTRL, ctrlWord(1'b0, i[0], i[1]));
			expect_out(20'h0, i[1] ? 2'b01 : i[0] ? 2'b10 : 2'b00, 1'b0);
		end
		cv = 20'($urandom);
		dv = 20'($urandom);
		wr(dac_ctrl_pkg::ADDR_CLEAR, cv);
		frame({dac_ctrl_pkg::RW_READ, dac_ctrl_pkg::ADDR_CLEAR,
			20'($urandom)});
		wr(3'h0, 20'($urandom));
		rdQ.push_back({dac_ctrl_pkg::RW_READ, dac_ctrl_pkg::ADDR_CLEAR, cv});
		-> readReady;
		wr(dac_ctrl_pkg::ADDR_DAC, dv);
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00002);
		expect_out(cv, 2'b00, 1'b0);
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'hFFFF8);
		expect_out(cv, 2'b00, 1'b0);
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00001);
		expect_out(dv, 2'b00, 1'b0);
		clearToCodeN = 1'b0;
		wr(dac_ctrl_pkg::ADDR_DAC, ~dv);
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00001);
		expect_out(cv, 2'b00, 1'b0);
		clearToCodeN = 1'b1;
		repeat (20) @(posedge clk);
		#5;
		expect_out(cv, 2'b00, 1'b0);
		loadOutputStrobeN = 1'b0;
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00002);
		expect_out(~dv, 2'b00, 1'b0);
		loadOutputStrobeN = 1'b1;
		wr(dac_ctrl_pkg::ADDR_CTRL, ctrlWord(1'b1, 1'b0, 1'b0));
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00002);
		expect_out(cv, 2'b00, 1'b1);
		// Frozen core holds the frame back until clock enable returns
		clkEnable = 1'b0;
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00001);
		expect_out(cv, 2'b00, 1'b1);
		clkEnable = 1'b1;
		repeat (14) @(posedge clk);
		#5;
		expect_out(~dv, 2'b00, 1'b1);
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00004);
		lin = 4'h0;
		rb = 1'b0;
		fl = 1'b1;
		expect_out(20'h0, 2'b01, 1'b0);
		wr(dac_ctrl_pkg::ADDR_SWCTRL, 20'h00002);
		expect_out(20'h0, 2'b01, 1'b0);
		#1;
		final_report;
	end
endmodule : testbench
